// File: clt_channel_test.sv
`timescale 1ns/1ps
module clt_channel_test #(
   parameter int unsigned addr_w = 15
) (
   input  wire logic                clock,
   input  wire logic                rst_b,
   input  wire clt_pkg::clt_cmd_e   cmd,
   input  wire logic                cmd_valid,
   input  wire logic                svc_busy,
   input  wire logic                pvc_mode,
   input  wire logic [1:0]          svc_free,
   input  wire logic [addr_w-1:0]   own_addr,
   input  wire logic                rx_break,
   input  wire logic [7:0]          rx_char,
   input  wire logic                rx_valid,
   input  wire logic                tx_ready,
   input  wire logic                call_placed_ok,
   input  wire logic                call_failed,
   input  wire logic                incoming_test_call,
   input  wire logic [7:0]          net_rx_char,
   input  wire logic                net_rx_valid,
   input  wire logic                net_tx_ready,
   output logic [7:0]               tx_char,
   output logic                     tx_valid,
   output logic                     call_req,
   output logic [addr_w-1:0]        call_addr,
   output logic                     accept_call,
   output logic                     clear_req,
   output logic [7:0]               net_tx_char,
   output logic                     net_tx_valid,
   output logic                     test_active,
   output logic                     prompt
);
   clt_msg_if rom_bus ();
   clt_msg_rom u_rom (
      .clock (clock),
      .rst_b (rst_b),
      .port  (rom_bus.rom)
   );

   function automatic logic [8:0] msg_base(input logic [7:0] m);
      msg_base = 9'(clt_pkg::fox_len + 2 + 32'(m) * clt_pkg::msg_len);
   endfunction

   clt_pkg::clt_state_e state, next_state;
   logic                system, next_system;
   logic [8:0]          ptr, next_ptr;
   logic [8:0]          stop, next_stop;
   logic                fetch, next_fetch;
   logic [7:0]          next_tx_char;
   logic                next_tx_valid, next_call_req, next_accept_call, next_clear_req;
   logic [7:0]          next_net_tx_char;
   logic                next_net_tx_valid;
   logic [addr_w-1:0]   next_call_addr;
   logic                fox_mode, next_fox_mode;
   clt_pkg::clt_state_e after, next_after;

   assign rom_bus.addr = ptr;

   always_comb begin
      next_state        = state;
      next_system       = system;
      next_ptr          = ptr;
      next_stop         = stop;
      next_fetch        = 1'b0;
      next_tx_char      = tx_char;
      next_tx_valid     = tx_valid && !tx_ready;
      next_call_req     = 1'b0;
      next_call_addr    = call_addr;
      next_accept_call  = 1'b0;
      next_clear_req    = 1'b0;
      next_net_tx_char  = net_tx_char;
      next_net_tx_valid = net_tx_valid && !net_tx_ready;
      next_fox_mode     = fox_mode;
      next_after        = after;
      // message streamer: one rom word per character, paced by the consumer ready
      if (fetch) begin
         if (fox_mode && (state == clt_pkg::st_loop)) begin
            next_net_tx_char  = rom_bus.data;
            next_net_tx_valid = 1'b1;
         end else begin
            next_tx_char  = rom_bus.data;
            next_tx_valid = 1'b1;
         end
         if (ptr == stop) begin
            if (fox_mode)
               next_ptr = 9'h000;
            else
               next_state = after;
         end else
            next_ptr = ptr + 9'h001;
      end
      case (state)
         clt_pkg::st_idle: begin
            next_fox_mode = 1'b0;
            if (cmd_valid && cmd != clt_pkg::cmd_none) begin
               if (svc_busy || pvc_mode || ((cmd != clt_pkg::cmd_terminal) && (svc_free != 2'h3))) begin
                  next_ptr   = msg_base(clt_pkg::msg_reject);
                  next_stop  = msg_base(clt_pkg::msg_reject) + 9'(clt_pkg::msg_len - 1);
                  next_after = clt_pkg::st_idle;
                  next_state = clt_pkg::st_end;
               end else if (cmd == clt_pkg::cmd_terminal) begin
                  next_ptr   = msg_base(clt_pkg::msg_in_test);
                  next_stop  = msg_base(clt_pkg::msg_in_test) + 9'(clt_pkg::msg_len - 1);
                  next_after = clt_pkg::st_fox;
                  next_state = clt_pkg::st_ack;
               end else begin
                  next_system    = (cmd == clt_pkg::cmd_system);
                  next_call_req  = 1'b1;
                  next_call_addr = own_addr;
                  next_state     = clt_pkg::st_call;
               end
            end
         end
         clt_pkg::st_ack, clt_pkg::st_placed, clt_pkg::st_com, clt_pkg::st_clear, clt_pkg::st_end: begin
            if (!fetch && !next_tx_valid && next_state == state)
               next_fetch = 1'b1;
            if (state == clt_pkg::st_placed && call_failed) begin
               next_ptr   = msg_base(clt_pkg::msg_clear);
               next_stop  = msg_base(clt_pkg::msg_clear) + 9'(clt_pkg::msg_len - 1);
               next_after = clt_pkg::st_idle;
               next_state = clt_pkg::st_clear;
               next_fetch = 1'b0;
            end
         end
         clt_pkg::st_call: begin
            if (call_failed) begin
               next_ptr   = msg_base(clt_pkg::msg_clear);
               next_stop  = msg_base(clt_pkg::msg_clear) + 9'(clt_pkg::msg_len - 1);
               next_after = clt_pkg::st_idle;
               next_state = clt_pkg::st_clear;
            end else if (call_placed_ok) begin
               next_ptr   = msg_base(clt_pkg::msg_placed);
               next_stop  = msg_base(clt_pkg::msg_placed) + 9'(clt_pkg::msg_len - 1);
               next_after = clt_pkg::st_wait_in;
               next_state = clt_pkg::st_placed;
            end
         end
         clt_pkg::st_wait_in: begin
            if (call_failed) begin
               next_ptr   = msg_base(clt_pkg::msg_clear);
               next_stop  = msg_base(clt_pkg::msg_clear) + 9'(clt_pkg::msg_len - 1);
               next_after = clt_pkg::st_idle;
               next_state = clt_pkg::st_clear;
            end else if (incoming_test_call) begin
               next_accept_call = 1'b1;
               next_ptr   = msg_base(clt_pkg::msg_com);
               next_stop  = msg_base(clt_pkg::msg_com) + 9'(clt_pkg::msg_len - 1);
               next_after = clt_pkg::st_loop;
               next_state = clt_pkg::st_com;
            end
         end
         clt_pkg::st_fox, clt_pkg::st_loop: begin
            if (state == clt_pkg::st_fox || system) begin
               if (fox_mode == 1'b0) begin
                  next_fox_mode = 1'b1;
                  next_ptr      = 9'h000;
                  next_stop     = 9'(clt_pkg::fox_len + 1);
               end else if (!fetch && (state == clt_pkg::st_fox ? !next_tx_valid : !next_net_tx_valid))
                  next_fetch = 1'b1;
            end
            if (state == clt_pkg::st_loop) begin
               if (!system && rx_valid && !next_net_tx_valid) begin
                  next_net_tx_char  = rx_char;
                  next_net_tx_valid = 1'b1;
               end
               if (net_rx_valid && !next_tx_valid) begin
                  next_tx_char  = net_rx_char;
                  next_tx_valid = 1'b1;
               end
            end
            if (rx_break) begin
               next_fox_mode  = 1'b0;
               next_fetch     = 1'b0;
               next_clear_req = (state == clt_pkg::st_loop);
               next_ptr   = msg_base(clt_pkg::msg_complete);
               next_stop  = msg_base(clt_pkg::msg_complete) + 9'(clt_pkg::msg_len - 1);
               next_after = clt_pkg::st_end;
               next_state = clt_pkg::st_clear;
            end
         end
         default: next_state = clt_pkg::st_idle;
      endcase
      if (state == clt_pkg::st_end && fetch && ptr == stop && after == clt_pkg::st_end) begin
         next_state = clt_pkg::st_end;
      end
      if (state == clt_pkg::st_clear && fetch && ptr == stop && after == clt_pkg::st_end) begin
         // prompt line follows the complete message
         next_ptr   = msg_base(clt_pkg::msg_reject);
         next_stop  = msg_base(clt_pkg::msg_reject) + 9'(clt_pkg::msg_len - 1);
         next_after = clt_pkg::st_idle;
         next_state = clt_pkg::st_end;
      end
   end

   // all state is local to one channel; other channels have their own instance
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state        <= clt_pkg::st_idle;
         system       <= 1'b0;
         ptr          <= 9'h000;
         stop         <= 9'h000;
         fetch        <= 1'b0;
         tx_char      <= 8'h00;
         tx_valid     <= 1'b0;
         call_req     <= 1'b0;
         call_addr    <= '0;
         accept_call  <= 1'b0;
         clear_req    <= 1'b0;
         net_tx_char  <= 8'h00;
         net_tx_valid <= 1'b0;
         fox_mode     <= 1'b0;
         after        <= clt_pkg::st_idle;
         test_active  <= 1'b0;
         prompt       <= 1'b1;
      end else begin
         state        <= next_state;
         system       <= next_system;
         ptr          <= next_ptr;
         stop         <= next_stop;
         fetch        <= next_fetch;
         tx_char      <= next_tx_char;
         tx_valid     <= next_tx_valid;
         call_req     <= next_call_req;
         call_addr    <= next_call_addr;
         accept_call  <= next_accept_call;
         clear_req    <= next_clear_req;
         net_tx_char  <= next_net_tx_char;
         net_tx_valid <= next_net_tx_valid;
         fox_mode     <= next_fox_mode;
         after        <= next_after;
         test_active  <= (next_state != clt_pkg::st_idle) && (next_state != clt_pkg::st_end);
         prompt       <= (next_state == clt_pkg::st_idle);
      end
   end
endmodule // clt_channel_test

// File: clt_channel_test_bench.sv
`timescale 1ns/1ps
module clt_channel_test_bench;
   logic clock, rst_b, cmd_valid, svc_busy, pvc_mode, rx_break, rx_valid, fail, slow;
   logic tx_ready, call_placed_ok, call_failed, incoming_test_call, net_rx_valid, net_tx_ready;
   logic tx_valid, call_req, accept_call, clear_req, net_tx_valid, test_active, prompt;
   logic [7:0]  rx_char, net_rx_char, tx_char, net_tx_char;
   logic [1:0]  svc_free;
   logic [14:0] own_addr, call_addr;
   clt_pkg::clt_cmd_e cmd;
   int   errors, n_tests, n_acc, n_clr;
   byte  q[$];
   string fox = "the quick brown fox jumps over the lazy dog 0123456789";
   clt_channel_test #(.addr_w(15)) dut (.*);
   clt_partner partner (.clock(clock), .rst_b(rst_b), .fail(fail), .slow(slow), .call_req(call_req),
      .net_tx_char(net_tx_char), .net_tx_valid(net_tx_valid), .tx_ready(tx_ready), .net_tx_ready(net_tx_ready),
      .call_placed_ok(call_placed_ok), .call_failed(call_failed), .incoming_test_call(incoming_test_call),
      .net_rx_char(net_rx_char), .net_rx_valid(net_rx_valid));
   initial begin
      clock = 0;
      forever #10 clock = ~clock;
   end
   always @(posedge clock) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1) q.push_back(tx_char);
      if (accept_call === 1'b1) n_acc++;
      if (clear_req === 1'b1) n_clr++;
   end
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(string what, logic [15:0] exp, logic [15:0] seen);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic get_line(output string s);
      byte c;
      s = "";
      for (int k = 0; k < 3000; k++) begin
         if (q.size() == 0) @(posedge clock);
         else begin
            c = q.pop_front();
            if (c == 8'h0a) break;
            s = {s, string'(c)};
         end
      end
      // padding and cr are not part of the text
      while (s.len() > 0 && (s[s.len()-1] == " " || s[s.len()-1] == 8'h0d)) s = s.substr(0, s.len() - 2);
   endtask
   task automatic line(string exp);
      string s;
      get_line(s);
      n_tests++;
      if (s != exp) begin
         errors++;
         $display("[ERR] line expected '%s' seen '%s'", exp, s);
      end
   endtask
   task automatic send(clt_pkg::clt_cmd_e c);
      @(negedge clock) cmd = c;
      cmd_valid = 1;
      @(negedge clock) cmd_valid = 0;
      cmd = clt_pkg::cmd_none;
   endtask
   task automatic finish_test(string name);
      string s;
      bit    done;
      @(negedge clock) rx_break = 1;
      @(negedge clock) rx_break = 0;
      // a cut sentence may share the line with the complete text
      for (int i = 0; i < 6 && !done; i++) begin
         get_line(s);
         done = (s.len() >= 13) && (s.substr(s.len() - 13, s.len() - 1) == "tact complete");
      end
      chk("complete seen", 1, done);
      line("*");
      for (int i = 0; i < 100 && prompt !== 1'b1; i++) @(negedge clock);
      chk("prompt", 1, prompt);
      repeat (40) @(negedge clock);
      q.delete();
      $display("test %s done", name);
   endtask
   task automatic t_reject();
      clt_pkg::clt_cmd_e c[3] = '{clt_pkg::cmd_terminal, clt_pkg::cmd_system, clt_pkg::cmd_remote};
      for (int i = 0; i < 3; i++) begin
         svc_busy = (i == 0);
         pvc_mode = (i == 1);
         svc_free = (i == 2) ? 2'b01 : 2'b11;
         send(c[i]);
         line("*");
         repeat (30) @(negedge clock);
         chk("refused idle", 16'h1, {test_active, prompt});
      end
      {svc_busy, pvc_mode, svc_free} = 4'h3;
      $display("test reject done");
   endtask
   task automatic t_terminal();
      send(clt_pkg::cmd_terminal);
      line("in tact mode");
      line(fox);
      line(fox);
      chk("no net traffic", 0, net_tx_valid);
      finish_test("terminal");
   endtask
   task automatic t_remote(logic f);
      int a = n_acc;
      int c = n_clr;
      fail = f;
      send(clt_pkg::cmd_remote);
      for (int k = 0; k < 20 && call_req !== 1'b1; k++) @(posedge clock);
      chk("call_addr", {1'b0, own_addr}, {1'b0, call_addr});
      line("tact call placed");
      line(f ? "clr" : "com");
      chk("accepted", f ? 0 : 1, n_acc - a);
      if (f) begin
         repeat (60) @(negedge clock);
         chk("idle after clear", 1, prompt);
         q.delete();
         fail = 0;
         return;
      end
      foreach (fox[i]) if (i < 3) begin
         @(negedge clock) rx_char = (i == 2) ? 8'h0a : fox[i];
         rx_valid = 1;
         @(negedge clock) rx_valid = 0;
         repeat (4) @(negedge clock);
      end
      line("th");
      finish_test("remote");
      chk("clear_req", 1, n_clr - c);
   endtask
   task automatic t_system();
      slow = 1;
      send(clt_pkg::cmd_system);
      line("tact call placed");
      line("com");
      line(fox);
      finish_test("system");
      slow = 0;
   endtask
   initial begin
      {rst_b, cmd_valid, svc_busy, pvc_mode, rx_break, rx_valid, fail, slow} = '0;
      cmd = clt_pkg::cmd_none;
      svc_free = 2'b11;
      own_addr = 15'h2b5a;
      rx_char = 8'h00;
      repeat (6) @(negedge clock);
      rst_b = 1;
      @(negedge clock);
      t_reject();
      t_terminal();
      t_remote(0);
      t_remote(1);
      t_system();
      end_of_test();
   end
   initial begin
      repeat (30000) @(posedge clock);
      errors++;
      end_of_test();
   end
endmodule // clt_channel_test_bench

// File: clt_channel_test_checker.sv
`timescale 1ns/1ps
module clt_channel_test_checker #(
   parameter int unsigned addr_w = 15
) (
   input wire logic              clock,
   input wire logic              rst_b,
   input wire clt_pkg::clt_cmd_e cmd,
   input wire logic              cmd_valid,
   input wire logic              svc_busy,
   input wire logic              pvc_mode,
   input wire logic [1:0]        svc_free,
   input wire logic [addr_w-1:0] own_addr,
   input wire logic              rx_break,
   input wire logic              tx_ready,
   input wire logic [7:0]        tx_char,
   input wire logic              tx_valid,
   input wire logic              call_req,
   input wire logic [addr_w-1:0] call_addr,
   input wire logic              accept_call,
   input wire logic              incoming_test_call,
   input wire logic              net_tx_ready,
   input wire logic [7:0]        net_tx_char,
   input wire logic              net_tx_valid,
   input wire logic              test_active,
   input wire logic              prompt
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   wire take = prompt && cmd_valid && !svc_busy && !pvc_mode;
   ack_first_a: assert property (take && cmd == clt_pkg::cmd_terminal |-> ##[1:4] tx_valid)
      else $error("terminal command not answered");
   tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_char))
      else $error("terminal char dropped before ready");
   call_addr_a: assert property (call_req |-> call_addr == own_addr)
      else $error("call request not self addressed");
   call_soon_a: assert property (take && svc_free == 2'b11 && cmd == clt_pkg::cmd_remote |-> ##[1:4] call_req)
      else $error("remote command gave no call request");
   loop_connect_a: assert property (incoming_test_call && !prompt |-> ##[1:4] accept_call)
      else $error("incoming test call not connected");
   net_hold_a: assert property (net_tx_valid && !net_tx_ready |=> net_tx_valid && $stable(net_tx_char))
      else $error("network char dropped before ready");
   need_two_a: assert property (take && svc_free != 2'b11 && cmd == clt_pkg::cmd_remote |=> !call_req [*4])
      else $error("call made without two circuits");
   refuse_busy_a: assert property (prompt && cmd_valid && (svc_busy || pvc_mode) |=> !call_req [*4])
      else $error("test started on busy channel");
   break_end_a: assert property (test_active && rx_break |-> ##[1:400] prompt)
      else $error("break did not end the test");
   idle_excl_a: assert property (!(prompt && test_active))
      else $error("prompt while test active");
   cover property (call_req ##[1:200] accept_call);
   cover property (tx_valid && !tx_ready);
   cover property (test_active && rx_break);
endmodule // clt_channel_test_checker

bind clt_channel_test clt_channel_test_checker #(.addr_w(addr_w)) u_chk (.clock(clock), .rst_b(rst_b), .cmd(cmd),
   .cmd_valid(cmd_valid), .svc_busy(svc_busy), .pvc_mode(pvc_mode), .svc_free(svc_free), .own_addr(own_addr),
   .rx_break(rx_break), .tx_ready(tx_ready), .tx_char(tx_char), .tx_valid(tx_valid), .call_req(call_req),
   .call_addr(call_addr), .accept_call(accept_call), .incoming_test_call(incoming_test_call),
   .net_tx_ready(net_tx_ready), .net_tx_char(net_tx_char), .net_tx_valid(net_tx_valid),
   .test_active(test_active), .prompt(prompt));

// File: clt_msg_if.sv
`timescale 1ns/1ps
interface clt_msg_if;
   logic [8:0] addr;
   logic [7:0] data;
   modport user (output addr, input data);
   modport rom  (input addr, output data);
endinterface

// File: clt_msg_rom.sv
`timescale 1ns/1ps
module clt_msg_rom (
   input  wire logic clock,
   input  wire logic rst_b,
   clt_msg_if.rom    port
);
   localparam string text =
      "the quick brown fox jumps over the lazy dog 0123456789\r\nin tact mode     \r\ntact call placed \r\ncom              \r\nclr              \r\ntact complete    \r\n*                \r\n";
   logic [7:0] next_data;
   always_comb begin
      next_data = 8'h00;
      if (int'(port.addr) < text.len())
         next_data = text[port.addr];
   end
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b)
         port.data <= 8'h00;
      else
         port.data <= next_data;
   end
endmodule // clt_msg_rom

// File: clt_partner.sv
`timescale 1ns/1ps
module clt_partner (
   input  wire logic       clock,
   input  wire logic       rst_b,
   input  wire logic       fail,
   input  wire logic       slow,
   input  wire logic       call_req,
   input  wire logic [7:0] net_tx_char,
   input  wire logic       net_tx_valid,
   output logic            tx_ready,
   output logic            net_tx_ready,
   output logic            call_placed_ok,
   output logic            call_failed,
   output logic            incoming_test_call,
   output logic [7:0]      net_rx_char,
   output logic            net_rx_valid
);
   int   cnt;
   logic nr;
   // the node answers late so the placed message is out before the call returns
   always @(negedge clock or negedge rst_b) begin
      if (!rst_b) begin
         {tx_ready, net_tx_ready, call_placed_ok, call_failed, incoming_test_call, net_rx_valid} <= '0;
         net_rx_char <= 8'h00;
         cnt <= 0;
      end else begin
         nr = slow ? ~net_tx_ready : 1'b1;
         tx_ready <= slow ? ~tx_ready : 1'b1;
         net_tx_ready <= nr;
         call_placed_ok <= (cnt == 3);
         call_failed <= (cnt == 120) && fail;
         incoming_test_call <= (cnt == 120) && !fail;
         cnt <= call_req ? 1 : (cnt != 0 && cnt < 120) ? cnt + 1 : 0;
         net_rx_valid <= net_tx_valid && nr;
         net_rx_char <= (net_tx_valid && nr) ? net_tx_char : ~net_rx_char;
      end
   end
endmodule // clt_partner

// File: clt_pkg.sv
package clt_pkg;
   localparam int unsigned clk_hz = 50000000;
   localparam logic [7:0] char_space = 8'h20;
   localparam logic [7:0] char_cr    = 8'h0d;
   localparam logic [7:0] char_lf    = 8'h0a;
   localparam int unsigned fox_len = 54;
   localparam int unsigned msg_len = 19;
   // message rom layout: sentence, then six service messages of 19 chars (space padded, cr lf ended)
   localparam logic [7:0] msg_in_test  = 8'h00;
   localparam logic [7:0] msg_placed   = 8'h01;
   localparam logic [7:0] msg_com      = 8'h02;
   localparam logic [7:0] msg_clear    = 8'h03;
   localparam logic [7:0] msg_complete = 8'h04;
   localparam logic [7:0] msg_reject   = 8'h05;
   typedef enum logic [1:0] {cmd_none, cmd_terminal, cmd_remote, cmd_system} clt_cmd_e;
   typedef enum logic [3:0] {st_idle, st_ack, st_fox, st_call, st_placed, st_wait_in, st_com,
                             st_loop, st_clear, st_end, st_reject} clt_state_e;
endpackage
